// ==== rtl/mbtcp_write_server.v ====
// Modbus TCP request handler for coil, register and event counter services.
`timescale 1ns/1ps
`default_nettype none
`include "mbtcp_write_defs.vh"
// How it works
// R01 - Function 0x05 writes one coil at the zero-based reference in bytes 8-9.
// R02 - Client puts the coil value in bytes 10-11; 0xFF then 0x00 means on.
// R03 - Good single coil write echoes 0x05, reference and both value bytes.
// R04 - Failed single coil write answers 0x85 with exception 0x01, 0x02 or 0x03.
// R05 - Function 0x06 writes the 16-bit value to the referenced output register.
// R06 - Good single register write answers with an exact echo of the request.
// R07 - Failed single register write answers 0x85 with exception 0x01 or 0x02.
// R08 - Function 0x0B returns a status word and the event counter.
// R09 - Counter counts good requests, not exceptions, polls or counter queries.
// R10 - Counter reply carries zero status in bytes 8-9, count in bytes 10-11.
// R11 - Client sends counter query with length 0x0002, unit and 0x0B only.
// R12 - Failed counter query answers 0x85 with exception 0x01.
// R13 - Function 0x0F writes consecutive coils, at most 256 in one request.
// R14 - Data byte LSB maps to the starting coil, bits ascend byte by byte.
// R15 - Client sends start in bytes 8-9, count 10-11, byte count 12, then data.
// R16 - Good multiple coil write answers 0x0F, start and count, without data.
// R17 - Failed multiple coil write answers 0x8F with exception 0x01 or 0x02.
// R18 - Response copies transaction and protocol ids and sets a matching length.
module mbtcp_write_server #(
  parameter COIL_COUNT = 17'h00100,
  parameter REG_COUNT  = 17'h00100
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire [7:0]  RX_DATA,
  input  wire        RX_VALID,
  input  wire        RX_LAST,
  output wire        RX_READY,
  output wire [7:0]  TX_DATA,
  output wire        TX_VALID,
  output wire        TX_LAST,
  input  wire        TX_READY,
  output wire        COIL_WE,
  output wire [15:0] COIL_ADDR,
  output wire        COIL_VAL,
  output wire        REG_WE,
  output wire [15:0] REG_ADDR,
  output wire [15:0] REG_DATA,
  output wire [15:0] EVENT_COUNT
);

  reg  [1:0]  state_reg;
  reg  [5:0]  rx_idx_reg;
  reg  [7:0]  req_reg [0:12];
  reg         last_seen_reg;
  reg         short_reg;
  reg  [7:0]  bits_byte_reg;
  reg  [15:0] bit_no_reg;
  reg  [7:0]  resp_reg [0:11];
  reg  [3:0]  tx_left_reg;
  reg         coil_we_reg;
  reg  [15:0] coil_addr_reg;
  reg         coil_val_reg;
  reg         reg_we_reg;
  reg  [15:0] reg_addr_reg;
  reg  [15:0] reg_data_reg;
  reg  [15:0] event_count_reg;
  integer     i;

  wire [7:0]  fc        = req_reg[7];
  wire [15:0] ref_num   = {req_reg[8], req_reg[9]};
  wire [15:0] value     = {req_reg[10], req_reg[11]};
  wire [15:0] len_field = {req_reg[4], req_reg[5]};
  wire [16:0] coil_end  = {1'b0, ref_num} + {1'b0, value};
  wire        rx_take   = RX_VALID && (state_reg == `ST_RECV);
  wire        tx_take   = TX_READY && (state_reg == `ST_SEND);
  wire [15:0] bit_coil  = ref_num + bit_no_reg;

  // Range checks for the multiple coil write; a zero count is refused as well.
  wire coils_ok = (value != 16'h0000) && ({1'b0, value} <= `MAX_COIL_BITS) &&
                  (coil_end <= COIL_COUNT); // [R13]
  wire bits_left = (bit_no_reg < value);
  wire take_bits = (fc == `FC_WRITE_COILS) && (rx_idx_reg >= `BYTE_FIRST_DATA) && coils_ok && bits_left;
  wire byte_done = (bit_no_reg[2:0] == 3'h7) || (bit_no_reg + 16'h0001 == value);

  // Minimum byte index that must have arrived for each function.
  reg  [5:0] need_idx;
  always @* begin
    if (fc == `FC_EVENT_COUNT) begin
      need_idx = `BYTE_FC;
    end else if (fc == `FC_WRITE_COILS) begin
      need_idx = `BYTE_COUNT;
    end else begin
      need_idx = `BYTE_VAL_LO;
    end
  end

  // Refusal reasons, settled in the execute cycle; 0x0F coil data is written earlier, in ST_BITS, only while coils_ok holds.
  wire frame_short    = short_reg || (rx_idx_reg <= need_idx);
  wire coil_addr_bad  = ({1'b0, ref_num} >= COIL_COUNT);
  wire coil_value_bad = (value != `COIL_ON_VALUE) && (value != `COIL_OFF_VALUE);
  wire reg_addr_bad   = ({1'b0, ref_num} >= REG_COUNT);
  wire query_len_bad  = (len_field != `LEN_EVENT_QUERY);

  // Only the low byte of a length field is sent from these; the high byte is always zero.
  wire [15:0] len_normal = `LEN_NORMAL_RESP;
  wire [15:0] len_exc    = `LEN_EXC_RESP;

  // Next state; the clocked block below only follows it.
  reg  [1:0]  state_next;
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_RECV: begin
        if (rx_take && take_bits) begin
          state_next = `ST_BITS;
        end else if (rx_take && RX_LAST) begin
          state_next = `ST_EXEC;
        end
      end
      `ST_BITS: begin
        // A frame cut short on a data byte still ends here, since its last flag was kept.
        if (byte_done) begin
          state_next = last_seen_reg ? `ST_EXEC : `ST_RECV;
        end
      end
      `ST_EXEC: begin
        state_next = `ST_SEND;
      end
      default: begin
        if (tx_take && (tx_left_reg == 4'h1)) begin
          state_next = `ST_RECV;
        end
      end
    endcase
  end

  // The counter moves only for good writes; refusals and counter queries leave it alone.
  reg  [15:0] event_count_next;
  always @* begin
    event_count_next = event_count_reg;
    if ((state_reg == `ST_EXEC) && !frame_short) begin
      if ((fc == `FC_WRITE_COIL) && !coil_addr_bad && !coil_value_bad) begin
        event_count_next = event_count_reg + 16'h0001; // [R09]
      end else if ((fc == `FC_WRITE_REG) && !reg_addr_bad) begin
        event_count_next = event_count_reg + 16'h0001; // [R09]
      end else if ((fc == `FC_WRITE_COILS) && coils_ok) begin
        event_count_next = event_count_reg + 16'h0001; // [R09]
      end
    end
  end

  assign RX_READY    = (state_reg == `ST_RECV);
  assign TX_VALID    = (state_reg == `ST_SEND);
  assign TX_LAST     = (state_reg == `ST_SEND) && (tx_left_reg == 4'h1);
  assign TX_DATA     = resp_reg[0];
  assign COIL_WE     = coil_we_reg;
  assign COIL_ADDR   = coil_addr_reg;
  assign COIL_VAL    = coil_val_reg;
  assign REG_WE      = reg_we_reg;
  assign REG_ADDR    = reg_addr_reg;
  assign REG_DATA    = reg_data_reg;
  assign EVENT_COUNT = event_count_reg;

  always @(posedge MCLK) begin
    if (RST) begin
      state_reg       <= `ST_RECV;
      rx_idx_reg      <= 6'h00;
      last_seen_reg   <= 1'b0;
      short_reg       <= 1'b0;
      bits_byte_reg   <= 8'h00;
      bit_no_reg      <= 16'h0000;
      tx_left_reg     <= 4'h0;
      coil_we_reg     <= 1'b0;
      coil_addr_reg   <= 16'h0000;
      coil_val_reg    <= 1'b0;
      reg_we_reg      <= 1'b0;
      reg_addr_reg    <= 16'h0000;
      reg_data_reg    <= 16'h0000;
      event_count_reg <= 16'h0000;
      for (i = 0; i < 13; i = i + 1) begin
        req_reg[i] <= 8'h00;
      end
      for (i = 0; i < 12; i = i + 1) begin
        resp_reg[i] <= 8'h00;
      end
    end else begin
      coil_we_reg     <= 1'b0;
      reg_we_reg      <= 1'b0;
      state_reg       <= state_next;
      event_count_reg <= event_count_next;
      case (state_reg)
        `ST_RECV: begin
          if (rx_take) begin
            if (rx_idx_reg <= `BYTE_LAST_SAVED) begin
              req_reg[rx_idx_reg[3:0]] <= RX_DATA;
            end
            if (rx_idx_reg != `BYTE_MAX_INDEX) begin
              rx_idx_reg <= rx_idx_reg + 6'h01;
            end
            last_seen_reg <= RX_LAST;
            // Data bytes are written out as they arrive, so no frame buffer is needed.
            if (take_bits) begin
              bits_byte_reg <= RX_DATA;
            end else if (RX_LAST) begin
              short_reg <= (rx_idx_reg < need_idx) && (rx_idx_reg < `BYTE_FC);
            end
          end
        end
        `ST_BITS: begin
          coil_we_reg   <= 1'b1;
          coil_addr_reg <= bit_coil;
          coil_val_reg  <= bits_byte_reg[bit_no_reg[2:0]]; // [R14]
          bit_no_reg    <= bit_no_reg + 16'h0001;
        end
        `ST_EXEC: begin
          // Header copy and default echo of bytes 7-11.
          for (i = 0; i < 4; i = i + 1) begin
            resp_reg[i] <= req_reg[i]; // [R18]
          end
          resp_reg[4]  <= 8'h00;
          resp_reg[5]  <= len_normal[7:0]; // [R18]
          resp_reg[6]  <= req_reg[6];
          resp_reg[7]  <= fc;
          resp_reg[8]  <= req_reg[8];
          resp_reg[9]  <= req_reg[9];
          resp_reg[10] <= req_reg[10];
          resp_reg[11] <= req_reg[11];
          tx_left_reg  <= `RESP_NORMAL_BYTES;
          short_reg    <= 1'b0;
          rx_idx_reg   <= 6'h00;
          bit_no_reg   <= 16'h0000;
          last_seen_reg <= 1'b0;
          if (frame_short) begin
            // A frame too short for its function is refused as an unknown request.
            resp_reg[5]  <= len_exc[7:0];
            resp_reg[7]  <= (fc == `FC_WRITE_COILS) ? `FC_EXC_COILS : `FC_EXC_SINGLE;
            resp_reg[8]  <= `EXC_ILL_FUNC;
            tx_left_reg  <= `RESP_EXC_BYTES;
          end else if (fc == `FC_WRITE_COIL) begin
            if (coil_addr_bad) begin
              resp_reg[5] <= len_exc[7:0];
              resp_reg[7] <= `FC_EXC_SINGLE; // [R04]
              resp_reg[8] <= `EXC_ILL_ADDR;
              tx_left_reg <= `RESP_EXC_BYTES;
            end else if (coil_value_bad) begin
              resp_reg[5] <= len_exc[7:0];
              resp_reg[7] <= `FC_EXC_SINGLE; // [R04]
              resp_reg[8] <= `EXC_ILL_VALUE;
              tx_left_reg <= `RESP_EXC_BYTES;
            end else begin
              coil_we_reg     <= 1'b1; // [R01]
              coil_addr_reg   <= ref_num;
              coil_val_reg    <= (value == `COIL_ON_VALUE); // [R02]
              // The default echo already holds 0x05, reference and value. [R03]
            end
          end else if (fc == `FC_WRITE_REG) begin
            if (reg_addr_bad) begin
              resp_reg[5] <= len_exc[7:0];
              resp_reg[7] <= `FC_EXC_SINGLE; // [R07]
              resp_reg[8] <= `EXC_ILL_ADDR;
              tx_left_reg <= `RESP_EXC_BYTES;
            end else begin
              reg_we_reg      <= 1'b1; // [R05]
              reg_addr_reg    <= ref_num;
              reg_data_reg    <= value;
              // Default echo is the exact request. [R06]
            end
          end else if (fc == `FC_EVENT_COUNT) begin
            if (query_len_bad) begin
              resp_reg[5] <= len_exc[7:0];
              resp_reg[7] <= `FC_EXC_SINGLE; // [R12]
              resp_reg[8] <= `EXC_ILL_FUNC;
              tx_left_reg <= `RESP_EXC_BYTES;
            end else begin
              // Counter queries do not count themselves. [R09]
              resp_reg[8]  <= 8'h00; // [R08] [R10]
              resp_reg[9]  <= 8'h00;
              resp_reg[10] <= event_count_reg[15:8];
              resp_reg[11] <= event_count_reg[7:0];
            end
          end else if (fc == `FC_WRITE_COILS) begin
            if (!coils_ok) begin
              resp_reg[5] <= len_exc[7:0];
              resp_reg[7] <= `FC_EXC_COILS; // [R17]
              resp_reg[8] <= `EXC_ILL_ADDR;
              tx_left_reg <= `RESP_EXC_BYTES;
            end else begin
              // Start and count stay in bytes 8-11; the data is not returned. [R16]
            end
          end else begin
            resp_reg[5] <= len_exc[7:0];
            resp_reg[7] <= fc | `FC_EXC_FLAG;
            resp_reg[8] <= `EXC_ILL_FUNC;
            tx_left_reg <= `RESP_EXC_BYTES;
          end
        end
        default: begin
          if (tx_take) begin
            for (i = 0; i < 11; i = i + 1) begin
              resp_reg[i] <= resp_reg[i + 1];
            end
            resp_reg[11] <= 8'h00;
            tx_left_reg  <= tx_left_reg - 4'h1;
          end
        end
      endcase
    end
  end

endmodule // mbtcp_write_server
`default_nettype wire

// ==== rtl/mbtcp_write_defs.vh ====
// Constants for the Modbus TCP write and event counter request handler.
`ifndef MBTCP_WRITE_DEFS_VH
`define MBTCP_WRITE_DEFS_VH

// Function codes that are served.
`define FC_WRITE_COIL      8'h05
`define FC_WRITE_REG       8'h06
`define FC_EVENT_COUNT     8'h0b
`define FC_WRITE_COILS     8'h0f

// Function codes used in exception replies.
`define FC_EXC_SINGLE      8'h85
`define FC_EXC_COILS       8'h8f
`define FC_EXC_FLAG        8'h80

// Exception codes.
`define EXC_ILL_FUNC       8'h01
`define EXC_ILL_ADDR       8'h02
`define EXC_ILL_VALUE      8'h03

// Coil on and off values in bytes 10-11.
`define COIL_ON_VALUE      16'hff00
`define COIL_OFF_VALUE     16'h0000

// Length field values.
`define LEN_EVENT_QUERY    16'h0002
`define LEN_NORMAL_RESP    16'h0006
`define LEN_EXC_RESP       16'h0003

// Byte positions inside the frame.
`define BYTE_FC            6'h07
`define BYTE_REF_LO        6'h09
`define BYTE_VAL_LO        6'h0b
`define BYTE_COUNT         6'h0c
`define BYTE_FIRST_DATA    6'h0d
`define BYTE_LAST_SAVED    6'h0c
`define BYTE_MAX_INDEX     6'h3f

// Frame sizes.
`define RESP_NORMAL_BYTES  4'hc
`define RESP_EXC_BYTES     4'h9

// Largest bit count of one multiple coil write.
`define MAX_COIL_BITS      17'h00100

// Handler states.
`define ST_RECV            2'h0
`define ST_EXEC            2'h1
`define ST_BITS            2'h2
`define ST_SEND            2'h3

`endif

// ==== tb/mbtcp_write_monitor.sv ====
// Port checker for the Modbus TCP write handler.
`timescale 1ns/1ps
`default_nettype none
module mbtcp_write_monitor (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        RX_VALID,
  input wire logic        RX_LAST,
  input wire logic        RX_READY,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_VALID,
  input wire logic        TX_LAST,
  input wire logic        TX_READY,
  input wire logic        COIL_WE,
  input wire logic [15:0] COIL_ADDR,
  input wire logic        REG_WE,
  input wire logic [15:0] EVENT_COUNT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [4:0] nb_reg;
  always_ff @(posedge MCLK) begin
    if (RST || (TX_VALID && TX_READY && TX_LAST)) nb_reg <= 5'h00;
    else if (TX_VALID && TX_READY) nb_reg <= nb_reg + 5'h01;
  end
  sequence s_req_end; RX_VALID && RX_READY && RX_LAST; endsequence
  sequence s_two_coils; COIL_WE ##1 COIL_WE; endsequence
  property p_busy; TX_VALID |-> !RX_READY; endproperty
  property p_answer; s_req_end |-> ##1 !TX_VALID ##[1:400] TX_VALID; endproperty
  property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  property p_len; TX_VALID && TX_READY && TX_LAST |-> nb_reg == 5'h0b || nb_reg == 5'h08; endproperty
  property p_reg; REG_WE |-> EVENT_COUNT == $past(EVENT_COUNT) + 16'h0001 ##1 !REG_WE; endproperty
  property p_step; !$past(RST) && $changed(EVENT_COUNT) |-> EVENT_COUNT == $past(EVENT_COUNT) + 16'h0001; endproperty
  property p_coil; s_two_coils |-> COIL_ADDR == $past(COIL_ADDR) + 16'h0001; endproperty
  property p_last; TX_LAST |-> TX_VALID; endproperty
  a_busy: assert property (p_busy) else $error("ready during response");
  a_answer: assert property (p_answer) else $error("late response");
  a_hold: assert property (p_hold) else $error("byte dropped");
  a_len: assert property (p_len) else $error("bad response size");
  a_reg: assert property (p_reg) else $error("register write count");
  a_step: assert property (p_step) else $error("counter jump");
  a_coil: assert property (p_coil) else $error("coil order");
  a_last: assert property (p_last) else $error("stray last");
endmodule // mbtcp_write_monitor
`default_nettype wire

// ==== tb/mb_client.sv ====
// Client model that sends one request frame and collects the response.
`timescale 1ns/1ps
`default_nettype none
module mb_client (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic         go,
  input  wire logic         slow,
  input  wire logic [135:0] req,
  input  wire logic [4:0]   nreq,
  input  wire logic         rx_ready,
  output var  logic [7:0]   rx_data = 8'h00,
  output var  logic         rx_valid = 1'b0,
  output var  logic         rx_last = 1'b0,
  input  wire logic [7:0]   tx_data,
  input  wire logic         tx_valid,
  input  wire logic         tx_last,
  output var  logic         tx_ready = 1'b0,
  output var  logic [95:0]  rsp = 96'h0,
  output var  logic [4:0]   nrsp = 5'h00,
  output var  logic         done = 1'b0
);
  logic [4:0] idx = 5'h00;
  always @(posedge MCLK) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (RST) begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
    end else if (go) begin
      idx <= 5'h00;
      rx_data <= req[135 -: 8];
      rx_valid <= 1'b1;
      rx_last <= (nreq == 5'h01);
      rsp <= 96'h0;
      nrsp <= 5'h00;
      done <= 1'b0;
    end else begin
      // Each byte stands until the edge that takes it, big-endian fields in frame order.
      if (rx_valid && rx_ready && !rx_last) begin
        idx <= idx + 5'h01;
        rx_data <= req[127 - 8 * idx -: 8];
        rx_last <= (idx + 5'h02 == nreq);
      end else if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
      end else if (!rx_valid) begin
        // A released bus must not keep showing the last byte.
        rx_data <= ~rx_data;
      end
      if (tx_valid && tx_ready) begin
        rsp[95 - 8 * nrsp -: 8] <= tx_data;
        nrsp <= nrsp + 5'h01;
        done <= tx_last;
      end
    end
  end
endmodule // mb_client
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the Modbus TCP write handler.
`timescale 1ns/1ps
`default_nettype none
`include "mbtcp_write_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic MCLK = 1'b0, RST = 1'b1, go = 1'b0, slow = 1'b0, done, rxv, rxl, rxr, txv, txl, txr, cwe, cval, rwe;
  logic [7:0] rxd, txd;
  logic [15:0] caddr, raddr, rdata, evc, cnt = 16'h0000;
  logic [135:0] req = '0;
  logic [4:0] nreq = 5'h01, nrsp;
  logic [95:0] rsp;
  logic [255:0] img;
  int fail_count = 0, tests_run = 0;
  always #5 MCLK = ~MCLK;
  always @(posedge MCLK) if (RST) img <= '0; else if (cwe) img[caddr[7:0]] <= cval;
  mbtcp_write_server i_mbtcp_write_server (.MCLK(MCLK), .RST(RST), .RX_DATA(rxd), .RX_VALID(rxv), .RX_LAST(rxl),
    .RX_READY(rxr), .TX_DATA(txd), .TX_VALID(txv), .TX_LAST(txl), .TX_READY(txr), .COIL_WE(cwe), .COIL_ADDR(caddr),
    .COIL_VAL(cval), .REG_WE(rwe), .REG_ADDR(raddr), .REG_DATA(rdata), .EVENT_COUNT(evc));
  mb_client i_mb_client (.MCLK(MCLK), .RST(RST), .go(go), .slow(slow), .req(req), .nreq(nreq), .rx_ready(rxr),
    .rx_data(rxd), .rx_valid(rxv), .rx_last(rxl), .tx_data(txd), .tx_valid(txv), .tx_last(txl), .tx_ready(txr),
    .rsp(rsp), .nrsp(nrsp), .done(done));
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task xfer(input logic [135:0] rq, input int n, input logic [95:0] ex, input int m);
    int k;
    req <= rq << (8 * (17 - n));
    nreq <= n[4:0];
    go <= 1'b1;
    @(posedge MCLK);
    go <= 1'b0;
    @(posedge MCLK);
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge MCLK);
    if (done !== 1'b1) begin
      fail_count++;
      give_verdict;
    end else begin
      `CHK(nrsp, m[4:0])
      `CHK(rsp, ex << (8 * (12 - m)))
    end
  endtask
  task t_reg;
    xfer(136'h0001_0000_0006_01_06_0001_1234, 12, 96'h0001_0000_0006_01_06_0001_1234, 12);
    cnt++;
    `CHK(raddr, 16'h0001)
    `CHK(rdata, 16'h1234)
    `CHK(evc, cnt)
    xfer(136'h0002_0000_0006_01_06_0100_5555, 12, 96'h0002_0000_0003_01_85_02, 9);
    `CHK(evc, cnt)
  endtask
  task t_coil;
    xfer(136'h0003_0000_0006_01_05_0001_ff00, 12, 96'h0003_0000_0006_01_05_0001_ff00, 12);
    cnt++;
    `CHK(caddr, 16'h0001)
    `CHK(cval, 1'b1)
    xfer(136'h0004_0000_0006_01_05_0002_1234, 12, 96'h0004_0000_0003_01_85_03, 9);
    `CHK(evc, cnt)
  endtask
  task t_event;
    xfer(136'h0005_0000_0002_01_0b, 8, {80'h0005_0000_0006_01_0b_0000, cnt}, 12);
    `CHK(evc, cnt)
    xfer(136'h0006_0000_0003_01_0b, 8, 96'h0006_0000_0003_01_85_01, 9);
    xfer(136'h000a_0000_0002_01, 7, 96'h000a_0000_0003_01_85_01, 9);
    `CHK(evc, cnt)
  endtask
  task t_reset;
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    `CHK(evc, 16'h0000)
    `CHK({rxr, txv, cwe, rwe}, 4'h8)
    cnt = 16'h0000;
    xfer(136'h000b_0000_0002_01_0b, 8, {80'h000b_0000_0006_01_0b_0000, cnt}, 12);
  endtask
  task t_coils;
    xfer(136'h0007_0000_0009_01_0f_0003_000a_02_a5ff, 15, 96'h0007_0000_0006_01_0f_0003_000a, 12);
    cnt++;
    `CHK(img[18:0], 19'h01d2a)
    `CHK(evc, cnt)
    xfer(136'h0008_0000_0009_01_0f_0000_0101_02_ffff, 15, 96'h0008_0000_0003_01_8f_02, 9);
    `CHK(img[18:0], 19'h01d2a)
  endtask
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    t_reg;
    slow <= 1'b1;
    t_coil;
    t_event;
    slow <= 1'b0;
    t_coils;
    t_reset;
    give_verdict;
  end
endmodule // tb_top
bind mbtcp_write_server mbtcp_write_monitor i_mbtcp_write_monitor (.MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID),
  .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST),
  .TX_READY(TX_READY), .COIL_WE(COIL_WE), .COIL_ADDR(COIL_ADDR), .REG_WE(REG_WE), .EVENT_COUNT(EVENT_COUNT));
`default_nettype wire
